// ==== dv/hold_master.sv ====
// Behavioural external master asking for the memory bus
`timescale 1ns/1ps
module hold_master (
   input logic clk_in,
   input logic want_in,
   input logic grant_n_in,
   output logic hold_request_n_out,
   output logic bus_drive_out
);
   always @(posedge clk_in) begin
      hold_request_n_out <= !want_in;
      // Drive stops with the request, or the cycle after grant goes if grant goes first
      bus_drive_out <= want_in && !grant_n_in;
   end
endmodule // hold_master

// ==== dv/pin_mux_hold_handshake_properties.sv ====
// Port assertions for the pin mux and hold handshake
`timescale 1ns/1ps
module pin_mux_checker (
   input logic clk_in,
   input logic rst_n_in,
   input logic rd_in,
   input logic [31:0] rdata_out,
   input logic pin14_in,
   input logic pin15_in,
   input logic bus_busy_in,
   input logic access_pending_in,
   input logic bus_float_out,
   input logic trip_zone_three_n_out,
   input logic trip_zone_four_n_out,
   input logic serial_b_rx_out,
   input logic frame_sync_in_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // ----------------------------
   // Output causes: pads after 3 or 4 cycles of sync, read strobe after 1, busy and pending after 2
   // ----------------------------
   a_read_slot_only: assert property (!$past(rd_in) |-> rdata_out == 32'h0000_0000)
      else $error("read data outside its slot");
   a_float_needs_request: assert property ($rose(bus_float_out) |-> !$past(pin14_in, 4))
      else $error("bus floated without request");
   a_float_ends_release: assert property ($fell(bus_float_out) |-> $past(pin14_in, 4))
      else $error("float ended while requested");
   a_float_waits_idle: assert property ($rose(bus_float_out) |->
      !$past(bus_busy_in, 2) && !$past(access_pending_in, 2))
      else $error("bus yielded while busy");
   a_trip3_from_pad: assert property ($fell(trip_zone_three_n_out) |->
      !$past(pin14_in, 3))
      else $error("trip three without low pad");
   a_trip4_from_pad: assert property ($fell(trip_zone_four_n_out) |->
      !$past(pin15_in, 3))
      else $error("trip four without low pad");
   a_rx_from_pad: assert property ($fell(serial_b_rx_out) |->
      !$past(pin15_in, 3))
      else $error("receive low without low pad");
   a_fsync_from_pad: assert property ($rose(frame_sync_in_out) |->
      $past(pin15_in, 3))
      else $error("frame sync high without high pad");
   c_float: cover property ($rose(bus_float_out));
   c_trip3: cover property ($fell(trip_zone_three_n_out));
   c_rx: cover property ($fell(serial_b_rx_out));
endmodule // pin_mux_checker

bind pin_mux_hold_handshake pin_mux_checker pin_mux_checker_inst (.clk_in, .rst_n_in,
   .rd_in, .rdata_out, .pin14_in, .pin15_in, .bus_busy_in, .access_pending_in, .bus_float_out,
   .trip_zone_three_n_out, .trip_zone_four_n_out, .serial_b_rx_out, .frame_sync_in_out);

// ==== dv/pin_mux_hold_handshake_tb.sv ====
// Self-checking bench for the pin mux and hold handshake
`timescale 1ns/1ps
`include "pin_mux_consts.vh"
module pin_mux_hold_handshake_tb;
   logic clk_in, rst_n_in, wr_in, rd_in, pin15_drv, tx, busy, pend, want, req_n, drive;
   logic [3:0] addr_in;
   logic [31:0] wdata_in, rdata_out;
   logic p15, p15_oe, p14, p14_oe, p13, p13_oe, rx, fs, tc, tz3_n, tz4_n, fl;
   logic [2:0] gin;
   int miscompares = 0;
   int comparisons = 0;
   wire pin15_in = p15_oe ? p15 : pin15_drv;
   wire pin14_in = p14_oe ? p14 : req_n;
   pin_mux_hold_handshake pin_mux_hold_handshake_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .pin15_in(pin15_in), .pin15_out(p15), .pin15_oe_out(p15_oe),
      .pin14_in(pin14_in), .pin14_out(p14), .pin14_oe_out(p14_oe), .pin13_in(1'b1),
      .pin13_out(p13), .pin13_oe_out(p13_oe), .gpio_out_in(3'h0), .gpio_in_out(gin),
      .serial_b_tx_in(tx), .serial_b_rx_out(rx), .frame_sync_out_in(tx),
      .frame_sync_oe_in(1'b0), .frame_sync_in_out(fs), .tx_clock_out_in(tx),
      .tx_clock_oe_in(1'b0), .tx_clock_in_out(tc), .trip_zone_three_n_out(tz3_n),
      .trip_zone_four_n_out(tz4_n), .bus_busy_in(busy), .access_pending_in(pend),
      .bus_float_out(fl));
   hold_master hold_master_inst (.clk_in(clk_in), .want_in(want), .grant_n_in(p15),
      .hold_request_n_out(req_n), .bus_drive_out(drive));
   // ----------------------------
   // Access and compare tasks
   // ----------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t bit %b expected %b", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      chk(rdata_out, exp);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic wait_float(input logic v);
      int n;
      n = 0;
      while (fl !== v && n < 20) begin
         tick(1);
         n++;
      end
      chk1(fl, v);
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ----------------------------
   // Clock, watchdog, tests
   // ----------------------------
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   initial begin
      #50000;
      miscompares++;
      results;
   end
   initial begin
      {rst_n_in, wr_in, rd_in, busy, pend, want} = 6'h00;
      {pin15_drv, tx} = 2'h3;
      addr_in = 4'h0;
      wdata_in = 32'h0000_0000;
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rd(`ADDR_MUX_LOW, `MUX_RESET);
      rd(4'hF, 32'h0000_0000);
      chk({29'h0000_0000, gin}, 32'h0000_0007);
      chk1(p13_oe, 1'b0);
      wr(`ADDR_MUX_LOW, 32'hFC00_0000);
      rd(`ADDR_MUX_LOW, `MUX_RESET);
      $display("reset and protection done");
      wr(`ADDR_CONTROL, 32'h0000_0001);
      wr(`ADDR_MUX_LOW, 32'hA000_0000);
      @(posedge clk_in);
      pin15_drv <= 1'b0;
      tx <= 1'b0;
      tick(5);
      chk1(rx, 1'b0);
      chk1(p14_oe, 1'b1);
      chk1(p14, 1'b0);
      wr(`ADDR_MUX_LOW, 32'hF000_0000);
      @(posedge clk_in);
      pin15_drv <= 1'b1;
      tick(5);
      chk1(fs, 1'b1);
      chk1(tc, 1'b1);
      chk1(rx, 1'b1);
      $display("serial codes done");
      wr(`ADDR_DIRECTION, 32'h0000_8000);
      wr(`ADDR_MUX_LOW, 32'h5000_0000);
      @(posedge clk_in);
      {busy, pend, want} <= 3'h7;
      tick(10);
      chk1(fl, 1'b0);
      @(posedge clk_in);
      busy <= 1'b0;
      tick(6);
      chk1(fl, 1'b0);
      @(posedge clk_in);
      pend <= 1'b0;
      wait_float(1'b1);
      tick(2);
      chk1(p15, 1'b0);
      chk1(drive, 1'b1);
      rd(`ADDR_STATUS, 32'h0000_0007);
      @(posedge clk_in);
      want <= 1'b0;
      wait_float(1'b0);
      tick(2);
      chk1(p15, 1'b1);
      $display("hold handshake done");
      wr(`ADDR_EXT_CFG2, 32'h0000_0001);
      @(posedge clk_in);
      want <= 1'b1;
      tick(12);
      chk1(fl, 1'b0);
      chk1(tz3_n, 1'b1);
      wr(`ADDR_CONTROL, 32'h0000_0007);
      wr(`ADDR_DIRECTION, 32'h0000_0000);
      @(posedge clk_in);
      pin15_drv <= 1'b0;
      tick(5);
      chk1(tz3_n, 1'b0);
      chk1(tz4_n, 1'b0);
      $display("mask and trip done");
      results;
   end
endmodule // pin_mux_hold_handshake_tb

// ==== rtl/hold_handshake.v ====
// Bus hold request/grant sequencer
`timescale 1ns/1ps
`include "pin_mux_consts.vh"
module hold_handshake (
   input wire clk_in,
   input wire rst_n_in,
   input wire request_in,
   input wire bus_busy_in,
   input wire access_pending_in,
   output reg granted_out,
   output reg bus_float_out
);
   localparam [1:0] ST_IDLE = `HOLD_IDLE;
   localparam [1:0] ST_DRAIN = `HOLD_DRAIN;
   localparam [1:0] ST_GRANTED = `HOLD_GRANTED;

   reg [1:0] state;
   reg [1:0] next_state;

   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (request_in) begin
               next_state = ST_DRAIN;
            end
         end
         ST_DRAIN: begin
            if (!request_in) begin
               next_state = ST_IDLE;
            end else if (!bus_busy_in && !access_pending_in) begin
               next_state = ST_GRANTED;
            end
         end
         ST_GRANTED: begin
            if (!request_in) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         state <= ST_IDLE;
         granted_out <= 1'b0;
         bus_float_out <= 1'b0;
      end else begin
         state <= next_state;
         granted_out <= (next_state == ST_GRANTED);
         bus_float_out <= (next_state == ST_GRANTED);
      end
   end
endmodule // hold_handshake

// ==== rtl/pin_mux_consts.vh ====
// Constants for the port A upper-pin multiplexer and bus hold handshake
//
// Contract
// - pin15_select bits 31-30, 00 GPIO at reset
// - 01: input trip four, output hold grant
// - Grant driven low after hold request granted
// - Bus address, data, strobes float while granted
// - Grant released after request released
// - pin15 code 10 is serial B receive
// - pin15 code 11 is frame sync, bidirectional
// - pin14_select bits 29-28, 00 GPIO at reset
// - pin14 code 01 trip three and request
// - Hold mask set ignores hold request
// - Mask clear: low trip three floats bus
// - Trip inputs ignored until software enables each
// - Yield bus only after accesses finish
// - pin14 code 10 drives serial B transmit
// - pin14 code 11 is transmit clock, bidirectional
// - pin13_select bits 27-26, 00 GPIO at reset
// - Mux writes need protected write enable
`ifndef PIN_MUX_CONSTS_VH
`define PIN_MUX_CONSTS_VH

// ------------------------------------------------------------
// Register addresses
// ------------------------------------------------------------
`define ADDR_MUX_LOW 4'h0
`define ADDR_DIRECTION 4'h1
`define ADDR_EXT_CFG2 4'h2
`define ADDR_CONTROL 4'h3
`define ADDR_STATUS 4'h4

// ------------------------------------------------------------
// Field positions and codes
// ------------------------------------------------------------
`define PIN15_HI 31
`define PIN15_LO 30
`define PIN14_HI 29
`define PIN14_LO 28
`define PIN13_HI 27
`define PIN13_LO 26
`define SEL_GPIO 2'h0
`define SEL_ALT1 2'h1
`define SEL_ALT2 2'h2
`define SEL_ALT3 2'h3
`define MUX_RESET 32'h0000_0000
`define DIR_PIN13 13
`define DIR_PIN14 14
`define DIR_PIN15 15
`define CFG2_HOLD_MASK 0
`define CTRL_PROT_EN 0
`define CTRL_TZ3_EN 1
`define CTRL_TZ4_EN 2
`define DIR_RESET 16'h0000

// ------------------------------------------------------------
// Hold states
// ------------------------------------------------------------
`define HOLD_IDLE 2'h0
`define HOLD_DRAIN 2'h1
`define HOLD_GRANTED 2'h2

`endif

// ==== rtl/pin_mux_hold_handshake.v ====
// Port A upper-pin multiplexer with external bus hold handshake
`timescale 1ns/1ps
`include "pin_mux_consts.vh"
module pin_mux_hold_handshake (
   input wire clk_in,
   input wire rst_n_in,
   input wire [3:0] addr_in,
   input wire [31:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   output reg [31:0] rdata_out,
   // Pin 15 (three-signal pad)
   input wire pin15_in,
   output reg pin15_out,
   output reg pin15_oe_out,
   // Pin 14
   input wire pin14_in,
   output reg pin14_out,
   output reg pin14_oe_out,
   // Pin 13
   input wire pin13_in,
   output reg pin13_out,
   output reg pin13_oe_out,
   // GPIO core side
   input wire [2:0] gpio_out_in,
   output reg [2:0] gpio_in_out,
   // Serial B
   input wire serial_b_tx_in,
   output reg serial_b_rx_out,
   // Buffered serial port B frame sync and clock
   input wire frame_sync_out_in,
   input wire frame_sync_oe_in,
   output reg frame_sync_in_out,
   input wire tx_clock_out_in,
   input wire tx_clock_oe_in,
   output reg tx_clock_in_out,
   // Trip zones toward the pwm unit, active low
   output reg trip_zone_three_n_out,
   output reg trip_zone_four_n_out,
   // External memory port status and float control
   input wire bus_busy_in,
   input wire access_pending_in,
   output reg bus_float_out
);
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   reg [31:0] port_a_mux_low_select;
   reg [15:0] port_a_direction;
   reg hold_request_mask;
   reg protected_write_enable;
   reg trip_three_enable;
   reg trip_four_enable;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   reg [2:0] pin_meta;
   reg [2:0] pin_sync;

   wire [1:0] pin15_select;
   wire [1:0] pin14_select;
   wire [1:0] pin13_select;
   wire pin15_is_output;
   wire hold_request;
   wire hold_granted;
   wire hold_float;

   assign pin15_select = port_a_mux_low_select[`PIN15_HI:`PIN15_LO];
   assign pin14_select = port_a_mux_low_select[`PIN14_HI:`PIN14_LO];
   assign pin13_select = port_a_mux_low_select[`PIN13_HI:`PIN13_LO];
   assign pin15_is_output = port_a_direction[`DIR_PIN15];

   // Low level on pin 14 in trip/hold mode requests the bus unless masked
   assign hold_request = (pin14_select == `SEL_ALT1) && !pin_sync[1] &&
      !hold_request_mask;

   function [31:0] read_mux;
      input [3:0] a;
      begin
         case (a)
            `ADDR_MUX_LOW: read_mux = port_a_mux_low_select;
            `ADDR_DIRECTION: read_mux = {16'h0000, port_a_direction};
            `ADDR_EXT_CFG2: read_mux = {31'h0000_0000, hold_request_mask};
            `ADDR_CONTROL: read_mux = {29'h0000_0000, trip_four_enable,
               trip_three_enable, protected_write_enable};
            `ADDR_STATUS: read_mux = {29'h0000_0000, bus_float_out,
               hold_request, hold_granted};
            default: read_mux = 32'h0000_0000;
         endcase
      end
   endfunction

   hold_handshake u_hold (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .request_in(hold_request),
      .bus_busy_in(bus_busy_in),
      .access_pending_in(access_pending_in),
      .granted_out(hold_granted),
      .bus_float_out(hold_float)
   );

   // ------------------------------------------------------------
   // Register bus
   // ------------------------------------------------------------
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         port_a_mux_low_select <= `MUX_RESET;
         port_a_direction <= `DIR_RESET;
         hold_request_mask <= 1'b0;
         protected_write_enable <= 1'b0;
         trip_three_enable <= 1'b0;
         trip_four_enable <= 1'b0;
         rdata_out <= 32'h0000_0000;
      end else begin
         if (wr_in) begin
            case (addr_in)
               `ADDR_MUX_LOW: begin
                  if (protected_write_enable) begin
                     port_a_mux_low_select <= wdata_in;
                  end
               end
               `ADDR_DIRECTION: begin
                  port_a_direction <= wdata_in[15:0];
               end
               `ADDR_EXT_CFG2: begin
                  hold_request_mask <= wdata_in[`CFG2_HOLD_MASK];
               end
               `ADDR_CONTROL: begin
                  protected_write_enable <= wdata_in[`CTRL_PROT_EN];
                  trip_three_enable <= wdata_in[`CTRL_TZ3_EN];
                  trip_four_enable <= wdata_in[`CTRL_TZ4_EN];
               end
               default: begin
               end
            endcase
         end
         rdata_out <= rd_in ? read_mux(addr_in) : 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------
   // Input synchronisers: only pin_sync is read by logic
   // ------------------------------------------------------------
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         pin_meta <= 3'h7;
         pin_sync <= 3'h7;
      end else begin
         pin_meta <= {pin13_in, pin14_in, pin15_in};
         pin_sync <= pin_meta;
      end
   end

   // ------------------------------------------------------------
   // Pin routing, registered so a select change lands next cycle
   // ------------------------------------------------------------
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         pin15_out <= 1'b0;
         pin15_oe_out <= 1'b0;
         pin14_out <= 1'b0;
         pin14_oe_out <= 1'b0;
         pin13_out <= 1'b0;
         pin13_oe_out <= 1'b0;
         gpio_in_out <= 3'h0;
         serial_b_rx_out <= 1'b1;
         frame_sync_in_out <= 1'b0;
         tx_clock_in_out <= 1'b0;
         trip_zone_three_n_out <= 1'b1;
         trip_zone_four_n_out <= 1'b1;
         bus_float_out <= 1'b0;
      end else begin
         // Inactive levels unless selected below
         serial_b_rx_out <= 1'b1;
         frame_sync_in_out <= 1'b0;
         tx_clock_in_out <= 1'b0;
         trip_zone_three_n_out <= 1'b1;
         trip_zone_four_n_out <= 1'b1;
         gpio_in_out <= {pin_sync[2], pin_sync[1], pin_sync[0]};
         // Pin 15
         case (pin15_select)
            `SEL_GPIO: begin
               pin15_out <= gpio_out_in[0];
               pin15_oe_out <= port_a_direction[`DIR_PIN15];
            end
            `SEL_ALT1: begin
               // Grant is active low, driven only when direction is output
               pin15_out <= !hold_granted;
               pin15_oe_out <= pin15_is_output;
               if (!pin15_is_output && trip_four_enable) begin
                  trip_zone_four_n_out <= pin_sync[0];
               end
            end
            `SEL_ALT2: begin
               pin15_out <= 1'b0;
               pin15_oe_out <= 1'b0;
               serial_b_rx_out <= pin_sync[0];
            end
            default: begin
               // Reserved where the buffered port is absent
               pin15_out <= frame_sync_out_in;
               pin15_oe_out <= frame_sync_oe_in;
               frame_sync_in_out <= pin_sync[0];
            end
         endcase
         // Pin 14
         case (pin14_select)
            `SEL_GPIO: begin
               pin14_out <= gpio_out_in[1];
               pin14_oe_out <= port_a_direction[`DIR_PIN14];
            end
            `SEL_ALT1: begin
               pin14_out <= 1'b0;
               pin14_oe_out <= 1'b0;
               if (trip_three_enable) begin
                  trip_zone_three_n_out <= pin_sync[1];
               end
            end
            `SEL_ALT2: begin
               pin14_out <= serial_b_tx_in;
               pin14_oe_out <= 1'b1;
            end
            default: begin
               pin14_out <= tx_clock_out_in;
               pin14_oe_out <= tx_clock_oe_in;
               tx_clock_in_out <= pin_sync[1];
            end
         endcase
         // Pin 13: only GPIO routing is handled here
         if (pin13_select == `SEL_GPIO) begin
            pin13_out <= gpio_out_in[2];
            pin13_oe_out <= port_a_direction[`DIR_PIN13];
         end else begin
            pin13_out <= 1'b0;
            pin13_oe_out <= 1'b0;
         end
         // Masked or not, the float follows the grant; master waits for it
         bus_float_out <= hold_float;
      end
   end
endmodule // pin_mux_hold_handshake
